/* verilog/ecr_pkg.sv */
package ecr_pkg;
   // clock and watchdog timing
   localparam int CLK_HZ       = 100_000_000;
   localparam int WD_TIMEOUT_S = 1;
   localparam int WD_CYC       = WD_TIMEOUT_S * CLK_HZ;
   // input register indices
   localparam logic [15:0] IR_ALARM  = 16'h0000;
   localparam logic [15:0] IR_POS_HI = 16'h0001;
   localparam logic [15:0] IR_POS_LO = 16'h0002;
   localparam logic [15:0] IR_RSVD   = 16'h0003;
   localparam logic [15:0] IR_BAD_HI = 16'h0004;
   localparam logic [15:0] IR_BAD_LO = 16'h0005;
   localparam logic [15:0] IR_RATE   = 16'h0006;
   localparam logic [15:0] IR_NODE   = 16'h0007;
   localparam logic [15:0] IR_SWVER  = 16'h0008;
   localparam logic [15:0] IR_HWVER  = 16'h0009;
   // holding register indices
   localparam logic [15:0] HR_PRE_HI = 16'h0004;
   localparam logic [15:0] HR_PRE_LO = 16'h0005;
   localparam logic [15:0] HR_OFS_HI = 16'h0006;
   localparam logic [15:0] HR_OFS_LO = 16'h0007;
   localparam logic [15:0] HR_CMD    = 16'h0009;
   localparam logic [15:0] HR_STATUS = 16'h000A;
   // field positions
   localparam int CMD_WD_EN  = 8;
   localparam int CMD_SAVE   = 9;
   localparam int CMD_DFLT   = 10;
   localparam int CMD_PRESET = 11;
   localparam int AL_BADPAR  = 0;
   localparam int AL_NVM     = 1;
   localparam int AL_WD      = 11;
   localparam int ST_ALARM   = 8;
   localparam int BAD_PRESET = 3;
   // reset and limit values
   localparam logic [15:0] CMD_RST    = 16'h0000;
   localparam logic [15:0] CMD_MASK   = 16'h0F00;
   localparam logic [31:0] PRESET_DEF = 32'h0000_0000;
   localparam logic [31:0] OFFSET_DEF = 32'h0000_0000;
   localparam logic [31:0] PRESET_MAX = 32'h0400_0000;
   localparam logic [7:0]  BAD_MASK   = 8'hFE;
   // version words, major:minor; values are arbitrary
   localparam logic [15:0] SW_VER = 16'h0001;
   localparam logic [15:0] HW_VER = 16'h0001;

   typedef struct packed {
      logic        write;   // 1 write, 0 read
      logic        in_reg;  // 1 input register space, 0 holding
      logic [15:0] addr;
      logic [15:0] wdata;
   } ecr_req_t;

   typedef struct packed {
      logic        err;     // unmapped index, or a write to an input or read-only holding register
      logic [15:0] rdata;
   } ecr_rsp_t;
endpackage : ecr_pkg

/* verilog/ecr_regs.sv */
// Summary of operation
// [RL1] command bit 8 enables/disables watchdog
// [RL2] one second silence sets alarm bit 11
// [RL3] watchdog alarm seen once traffic resumes
// [RL4] watchdog alarm self-clears when communication restored
// [RL5] bit 9 rising edge triggers save
// [RL6] bit 10 rising edge restores factory defaults
// [RL7] bit 11 rising edge captures position as offset
// [RL8] offset volatile until saved by master
// [RL9] input registers read-only, writes ignored
// [RL10] alarm bit0 bad parameter, bit1 memory fault
// [RL11] bad parameter alarm holds until fixed
// [RL12] memory fault alarm never clears
// [RL13] position signed 32-bit, sampled at request
// [RL14] input register 0x03 reserved, reads zero
// [RL15] wrong-parameter list bits 1 to 7
// [RL16] line setting reports switch code 0..8
// [RL17] node address reports switch setting
// [RL18] versions: major high byte, minor low
// [RL19] position = raw + preset - offset
// [RL20] status bit 8 shows any alarm
// [RL21] command bits kept, act on rising edge
module ecr_regs #(
   parameter int WD_TIMEOUT_CYC = ecr_pkg::WD_CYC
) (
   input  wire logic             i_clk,
   input  wire logic             i_rstn,
   input  wire logic             i_req_valid,
   input  wire ecr_pkg::ecr_req_t i_req,
   input  wire logic             i_msg_rx,
   input  wire logic [31:0]      i_raw_pos,
   input  wire logic [7:0]       i_param_bad,
   input  wire logic             i_nvm_fault,
   input  wire logic [3:0]       i_sw_rate,
   input  wire logic [7:0]       i_sw_node,
   output logic                  o_rsp_valid,
   output ecr_pkg::ecr_rsp_t     o_rsp,
   output logic                  o_save_req,
   output logic                  o_load_dflt,
   output logic                  o_wd_enable,
   output logic                  o_alarm_active
);
   import ecr_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // switch synchronisers, pins are asynchronous
   logic [11:0] sw_meta_q;
   logic [11:0] sw_sync_q;

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sw_meta_q <= 12'h000;
         sw_sync_q <= 12'h000;
      end else begin
         sw_meta_q <= {i_sw_node, i_sw_rate};
         sw_sync_q <= sw_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [15:0] cmd_q, cmd_d;
   logic [31:0] preset_q, preset_d;
   logic [31:0] offset_q, offset_d;
   logic [31:0] pos_lat_q, pos_lat_d;
   logic        nvm_q, nvm_d;
   logic        wd_al_q, wd_al_d;
   logic        wd_seen_q, wd_seen_d;
   logic [31:0] wd_cnt_q, wd_cnt_d;
   logic        rsp_v_q, rsp_v_d;
   ecr_rsp_t    rsp_q, rsp_d;
   logic        save_q, save_d;
   logic        dflt_q, dflt_d;
   logic        alarm_q, alarm_d;

   logic        wr_hold;
   logic        rd_req;
   logic [15:0] rise;
   logic [31:0] pos_now;
   logic [7:0]  bad_list;
   logic [15:0] alarm_word;
   logic        wd_expire;

   // reported position, signed wrap arithmetic
   assign pos_now = i_raw_pos + preset_q - offset_q;  // [RL19]
   assign wr_hold = i_req_valid && i_req.write && !i_req.in_reg;
   assign rd_req  = i_req_valid && !i_req.write;
   // edges against the retained command value
   assign rise = wr_hold && i_req.addr == HR_CMD
                 ? (i_req.wdata & ~cmd_q & CMD_MASK) : 16'h0000;  // [RL21]
   // outside checker flags items live, so bits fall once fixed
   always_comb begin
      bad_list = i_param_bad & BAD_MASK;  // [RL15]
      bad_list[BAD_PRESET] = i_param_bad[BAD_PRESET] || preset_q > PRESET_MAX;
   end

   always_comb begin
      alarm_word = 16'h0000;
      alarm_word[AL_BADPAR] = |bad_list;  // [RL10] [RL11]
      alarm_word[AL_NVM]    = nvm_q;      // [RL10]
      alarm_word[AL_WD]     = wd_al_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // watchdog: counts silence, reloaded by every frame
   assign wd_expire = cmd_q[CMD_WD_EN] && wd_cnt_q == 32'(WD_TIMEOUT_CYC - 1);

   always_comb begin
      wd_cnt_d  = wd_cnt_q;
      wd_al_d   = wd_al_q;
      wd_seen_d = wd_seen_q;
      // park one past the limit so a gap yields a single timeout event,
      // otherwise the first frame after silence would re-arm the alarm
      if (!cmd_q[CMD_WD_EN] || i_msg_rx) begin
         wd_cnt_d = 32'h0000_0000;  // [RL1]
      end else if (wd_cnt_q != 32'(WD_TIMEOUT_CYC)) begin
         wd_cnt_d = wd_cnt_q + 32'h0000_0001;
      end
      // first frame after silence still reports the alarm
      if (i_msg_rx && wd_al_q) begin
         if (wd_seen_q) begin
            wd_al_d   = 1'b0;  // [RL4]
            wd_seen_d = 1'b0;
         end else begin
            wd_seen_d = 1'b1;  // [RL3]
         end
      end
      // a timeout outranks a clear in the same cycle
      if (wd_expire) begin
         wd_al_d   = 1'b1;  // [RL2]
         wd_seen_d = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // holding writes, commands and parameter store
   always_comb begin
      cmd_d    = cmd_q;
      preset_d = preset_q;
      offset_d = offset_q;
      save_d   = rise[CMD_SAVE];  // [RL5]
      dflt_d   = rise[CMD_DFLT];
      // fault is sticky, only reset clears it
      nvm_d    = nvm_q || i_nvm_fault;  // [RL12]
      if (wr_hold) begin
         case (i_req.addr)
            HR_CMD:    cmd_d = i_req.wdata & CMD_MASK;  // [RL1] [RL21]
            HR_PRE_HI: preset_d[31:16] = i_req.wdata;
            HR_PRE_LO: preset_d[15:0]  = i_req.wdata;
            default:   cmd_d = cmd_q;  // offset only moves by command
         endcase
      end
      // capture offset from the raw count so reported equals preset
      if (rise[CMD_PRESET]) begin
         offset_d = i_raw_pos;  // [RL7] [RL8]
      end
      // defaults override anything written alongside
      if (rise[CMD_DFLT]) begin
         preset_d = PRESET_DEF;  // [RL6]
         offset_d = OFFSET_DEF;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; input writes are answered but change nothing
   always_comb begin
      rsp_v_d   = i_req_valid;
      rsp_d     = '0;
      pos_lat_d = pos_lat_q;
      alarm_d   = |alarm_word;  // [RL20]
      if (rd_req && i_req.in_reg) begin
         case (i_req.addr)
            IR_ALARM:  rsp_d.rdata = alarm_word;
            IR_POS_HI: begin
               pos_lat_d   = pos_now;  // [RL13]
               rsp_d.rdata = pos_now[31:16];
            end
            IR_POS_LO: rsp_d.rdata = pos_lat_q[15:0];  // [RL13]
            IR_RSVD:   rsp_d.rdata = 16'h0000;  // [RL14]
            IR_BAD_HI: rsp_d.rdata = 16'h0000;
            IR_BAD_LO: rsp_d.rdata = {8'h00, bad_list};  // [RL15]
            IR_RATE:   rsp_d.rdata = {12'h000, sw_sync_q[3:0]};  // [RL16]
            IR_NODE:   rsp_d.rdata = {8'h00, sw_sync_q[11:4]};  // [RL17]
            IR_SWVER:  rsp_d.rdata = SW_VER;  // [RL18]
            IR_HWVER:  rsp_d.rdata = HW_VER;  // [RL18]
            default:   rsp_d.err = 1'b1;
         endcase
      end else if (rd_req) begin
         case (i_req.addr)
            HR_PRE_HI: rsp_d.rdata = preset_q[31:16];
            HR_PRE_LO: rsp_d.rdata = preset_q[15:0];
            HR_OFS_HI: rsp_d.rdata = offset_q[31:16];
            HR_OFS_LO: rsp_d.rdata = offset_q[15:0];
            HR_CMD:    rsp_d.rdata = cmd_q;
            HR_STATUS: rsp_d.rdata[ST_ALARM] = |alarm_word;  // [RL20]
            default:   rsp_d.err = 1'b1;
         endcase
      end else if (i_req_valid && i_req.in_reg) begin
         rsp_d.err = 1'b1;  // [RL9]
      end else if (i_req_valid) begin
         case (i_req.addr)
            HR_CMD, HR_PRE_HI, HR_PRE_LO: rsp_d.err = 1'b0;
            default:                      rsp_d.err = 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cmd_q     <= CMD_RST;
         preset_q  <= PRESET_DEF;
         offset_q  <= OFFSET_DEF;
         pos_lat_q <= 32'h0000_0000;
         nvm_q     <= 1'b0;
         wd_al_q   <= 1'b0;
         wd_seen_q <= 1'b0;
         wd_cnt_q  <= 32'h0000_0000;
         rsp_v_q   <= 1'b0;
         rsp_q     <= '0;
         save_q    <= 1'b0;
         dflt_q    <= 1'b0;
         alarm_q   <= 1'b0;
      end else begin
         cmd_q     <= cmd_d;
         preset_q  <= preset_d;
         offset_q  <= offset_d;
         pos_lat_q <= pos_lat_d;
         nvm_q     <= nvm_d;
         wd_al_q   <= wd_al_d;
         wd_seen_q <= wd_seen_d;
         wd_cnt_q  <= wd_cnt_d;
         rsp_v_q   <= rsp_v_d;
         rsp_q     <= rsp_d;
         save_q    <= save_d;
         dflt_q    <= dflt_d;
         alarm_q   <= alarm_d;
      end
   end

   // all outputs straight from flops
   assign o_rsp_valid    = rsp_v_q;
   assign o_rsp          = rsp_q;
   assign o_save_req     = save_q;
   assign o_load_dflt    = dflt_q;
   assign o_wd_enable    = cmd_q[CMD_WD_EN];
   assign o_alarm_active = alarm_q;
endmodule : ecr_regs

/* dv/ecr_regs_properties.sv */
module ecr_regs_properties #(
   parameter int WD_TIMEOUT_CYC = 50
) (
   input  wire logic              i_clk,
   input  wire logic              i_rstn,
   input  wire logic              i_req_valid,
   input  wire ecr_pkg::ecr_req_t i_req,
   input  wire logic              i_msg_rx,
   input  wire logic              i_nvm_fault,
   input  wire logic              o_rsp_valid,
   input  wire ecr_pkg::ecr_rsp_t o_rsp,
   input  wire logic              o_save_req,
   input  wire logic              o_load_dflt,
   input  wire logic              o_wd_enable,
   input  wire logic              o_alarm_active
);
   import ecr_pkg::*;
   logic cmd_wr, save_wr, dflt_wr;
   int   wd_cnt_q;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   // holding writes to the command word
   assign cmd_wr  = i_req_valid && i_req.write && !i_req.in_reg && i_req.addr == HR_CMD;
   assign save_wr = cmd_wr && i_req.wdata[CMD_SAVE];
   assign dflt_wr = cmd_wr && i_req.wdata[CMD_DFLT];
   // silence counter, saturating so the timeout check fires once per gap
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) wd_cnt_q <= 0;
      else if (!o_wd_enable || i_msg_rx) wd_cnt_q <= 0;
      else if (wd_cnt_q < WD_TIMEOUT_CYC + 8) wd_cnt_q <= wd_cnt_q + 1;
   end
   ////////////////////////////////////////////////////////////////////////
   AST_RSP_LAT: assert property (i_req_valid |=> o_rsp_valid) else $error("late response");
   AST_RSP_IDLE: assert property (!i_req_valid |=> !o_rsp_valid && o_rsp == '0)
      else $error("stray response");
   AST_IN_WRITE: assert property (i_req_valid && i_req.write && i_req.in_reg |=> o_rsp.err)
      else $error("input write accepted");
   AST_RSVD: assert property (i_req_valid && i_req.in_reg && i_req.addr == IR_RSVD
      |=> o_rsp.rdata == 16'h0000) else $error("reserved word not zero");
   AST_WD_ON: assert property (cmd_wr && i_req.wdata[CMD_WD_EN] |=> o_wd_enable)
      else $error("watchdog not enabled");
   AST_WD_OFF: assert property (cmd_wr && !i_req.wdata[CMD_WD_EN] |=> !o_wd_enable)
      else $error("watchdog not disabled");
   AST_SAVE: assert property (o_save_req |-> $past(save_wr)) else $error("save w/o cause");
   AST_DFLT: assert property (o_load_dflt |-> $past(dflt_wr)) else $error("dflt w/o cause");
   AST_NVM: assert property (i_nvm_fault |-> ##[1:3] o_alarm_active)
      else $error("memory fault not flagged");
   AST_NVM_HOLD: assert property (i_nvm_fault |-> ##3 o_alarm_active [*8])
      else $error("memory fault cleared");
   AST_WD_TO: assert property (wd_cnt_q == WD_TIMEOUT_CYC + 6 |-> o_alarm_active)
      else $error("watchdog timeout missed");
   // main scenarios reached
   cover property (o_save_req);
   cover property (o_load_dflt);
   cover property (wd_cnt_q == WD_TIMEOUT_CYC + 6);
endmodule : ecr_regs_properties
bind ecr_regs ecr_regs_properties #(.WD_TIMEOUT_CYC(WD_TIMEOUT_CYC)) chk_u (
   .i_clk, .i_rstn, .i_req_valid, .i_req, .i_msg_rx, .i_nvm_fault, .o_rsp_valid,
   .o_rsp, .o_save_req, .o_load_dflt, .o_wd_enable, .o_alarm_active);

/* dv/ecr_master_model.sv */
module ecr_master_model (
   input  wire logic              i_clk,
   input  wire logic              i_rsp_valid,
   input  wire ecr_pkg::ecr_rsp_t i_rsp,
   output logic                   o_req_valid,
   output ecr_pkg::ecr_req_t      o_req,
   output logic                   o_msg_rx
);
   timeunit 1ns;
   timeprecision 100ps;
   import ecr_pkg::*;
   // idle bus at time zero
   initial begin
      o_req_valid = 1'b0;
      o_msg_rx    = 1'b0;
      o_req       = '0;
   end
   // one decoded frame; every frame is traffic for the watchdog
   task automatic xfer(input logic w, input logic s, input logic [15:0] a,
                       input logic [15:0] wd, output logic v, output ecr_rsp_t r);
      @(negedge i_clk);
      o_req_valid = 1'b1;
      o_msg_rx    = 1'b1;
      o_req       = '{w, s, a, wd};
      @(negedge i_clk);
      o_req_valid = 1'b0;
      o_msg_rx    = 1'b0;
      o_req       = ~o_req; // no stale value after release
      v = i_rsp_valid;
      r = i_rsp;
   endtask : xfer
endmodule : ecr_master_model

/* dv/ecr_regs_bench.sv */
module ecr_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import ecr_pkg::*;
   localparam int WD = 50;
   localparam logic RD = 1'b0, WR = 1'b1, IS = 1'b1, HS = 1'b0;
   logic        i_clk, i_rstn, i_req_valid, i_msg_rx, i_nvm_fault, v;
   logic        o_rsp_valid, o_save_req, o_load_dflt, o_wd_enable, o_alarm_active;
   ecr_req_t    i_req;
   ecr_rsp_t    o_rsp, r;
   logic [31:0] i_raw_pos, pre, ofs;
   logic [7:0]  i_param_bad, i_sw_node;
   logic [3:0]  i_sw_rate;
   logic [15:0] d, ta [5], te [5], cw [6];
   int          mismatches, checked, n_save, n_dflt, seed_v, es [6], ed [6];
   ecr_regs #(.WD_TIMEOUT_CYC(WD)) dut_u (.i_clk, .i_rstn, .i_req_valid, .i_req, .i_msg_rx,
      .i_raw_pos, .i_param_bad, .i_nvm_fault, .i_sw_rate, .i_sw_node, .o_rsp_valid, .o_rsp,
      .o_save_req, .o_load_dflt, .o_wd_enable, .o_alarm_active);
   ecr_master_model master_u (.i_clk, .i_rsp_valid(o_rsp_valid), .i_rsp(o_rsp),
      .o_req_valid(i_req_valid), .o_req(i_req), .o_msg_rx(i_msg_rx));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // pulses counted at the edge after they launch
   always @(posedge i_clk) begin
      if (o_save_req === 1'b1) n_save++;
      if (o_load_dflt === 1'b1) n_dflt++;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask : chk16
   task automatic chk1(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s exp %b got %b", n, e, g);
      end
   endtask : chk1
   task automatic acc(input logic w, input logic s, input logic [15:0] a, input logic [15:0] x);
      master_u.xfer(w, s, a, x, v, r);
      chk1("rsp_valid", 1'b1, v);
      d = r.rdata;
   endtask : acc
   function automatic logic [31:0] exp_pos(input logic [31:0] raw, p, o);
      return raw + p - o;
   endfunction : exp_pos
   task automatic rd_pos(input logic [31:0] e);
      acc(RD, IS, IR_POS_HI, 16'h0000);
      chk16("pos_hi", e[31:16], d);
      acc(RD, IS, IR_POS_LO, 16'h0000);
      chk16("pos_lo", e[15:0], d);
   endtask : rd_pos
   task automatic summarize;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////
   initial begin
      i_rstn = 1'b0;
      i_nvm_fault = 1'b0;
      i_param_bad = 8'h00;
      seed_v = $urandom(26);
      i_raw_pos = $urandom;
      i_sw_rate = 4'($urandom % 9);
      i_sw_node = 8'($urandom);
      repeat (20) @(posedge i_clk);
      @(negedge i_clk) i_rstn = 1'b1;
      repeat (3) @(negedge i_clk);
      ta = '{IR_SWVER, IR_HWVER, IR_RSVD, IR_RATE, IR_NODE};
      te = '{SW_VER, HW_VER, 16'h0000, {12'h000, i_sw_rate}, {8'h00, i_sw_node}};
      foreach (ta[k]) begin
         acc(RD, IS, ta[k], 16'h0000);
         chk16("ident", te[k], d);
      end
      acc(WR, IS, IR_RATE, 16'hFFFF);
      chk1("in_write_err", 1'b1, r.err);
      acc(RD, IS, IR_RATE, 16'h0000);
      chk16("rate_kept", te[3], d);
      $display("test ident done");
      i_param_bad = 8'($urandom) | 8'h02;
      acc(RD, IS, IR_ALARM, 16'h0000);
      chk16("alarm_bad", 16'h0001, d);
      acc(RD, IS, IR_BAD_LO, 16'h0000);
      chk16("bad_list", {8'h00, i_param_bad & BAD_MASK}, d);
      i_param_bad = 8'h00;
      acc(RD, IS, IR_BAD_LO, 16'h0000);
      chk16("bad_fixed", 16'h0000, d);
      acc(RD, IS, IR_ALARM, 16'h0000);
      chk16("alarm_fixed", 16'h0000, d);
      $display("test params done");
      pre = $urandom % (PRESET_MAX + 1);
      acc(WR, HS, HR_PRE_HI, pre[31:16]);
      acc(WR, HS, HR_PRE_LO, pre[15:0]);
      ofs = i_raw_pos;
      acc(WR, HS, HR_CMD, 16'h0800);
      rd_pos(exp_pos(i_raw_pos, pre, ofs));
      acc(RD, HS, HR_OFS_LO, 16'h0000);
      chk16("offset", ofs[15:0], d);
      // offset is read-only: only the preset and defaults commands may move it
      acc(WR, HS, HR_OFS_LO, 16'hFFFF);
      chk1("ofs_wr_err", 1'b1, r.err);
      acc(RD, HS, HR_OFS_LO, 16'h0000);
      chk16("offset_kept", ofs[15:0], d);
      i_raw_pos = i_raw_pos + 32'($urandom % 1000);
      rd_pos(exp_pos(i_raw_pos, pre, ofs));
      $display("test preset done");
      cw = '{16'h0200, 16'h0200, 16'h0000, 16'h0200, 16'h0400, 16'h0400};
      es = '{1, 1, 1, 2, 2, 2};
      ed = '{0, 0, 0, 0, 1, 1};
      foreach (cw[k]) begin
         acc(WR, HS, HR_CMD, cw[k]);
         @(negedge i_clk);
         chk16("saves", 16'(es[k]), 16'(n_save));
         chk16("defaults", 16'(ed[k]), 16'(n_dflt));
      end
      rd_pos(exp_pos(i_raw_pos, 32'h0000_0000, 32'h0000_0000));
      $display("test commands done");
      acc(WR, HS, HR_CMD, 16'h0100);
      chk1("wd_on", 1'b1, o_wd_enable);
      repeat (WD + 10) @(negedge i_clk);
      chk1("alarm_active", 1'b1, o_alarm_active);
      // first frame shows the alarm, second clears it after answering
      acc(RD, IS, IR_ALARM, 16'h0000);
      chk16("wd_alarm", 16'h0800, d);
      acc(RD, IS, IR_ALARM, 16'h0000);
      chk16("wd_restored", 16'h0800, d);
      acc(RD, IS, IR_ALARM, 16'h0000);
      chk16("wd_cleared", 16'h0000, d);
      acc(WR, HS, HR_CMD, 16'h0000);
      chk1("wd_off", 1'b0, o_wd_enable);
      $display("test watchdog done");
      i_nvm_fault = 1'b1;
      @(negedge i_clk) i_nvm_fault = 1'b0;
      acc(WR, HS, HR_CMD, 16'h0400);
      acc(RD, IS, IR_ALARM, 16'h0000);
      chk16("nvm_alarm", 16'h0002, d);
      acc(RD, HS, HR_STATUS, 16'h0000);
      chk16("status_alarm", 16'h0100, d);
      // let the hold window of the fault run out before ending
      repeat (12) @(negedge i_clk);
      chk1("nvm_kept", 1'b1, o_alarm_active);
      $display("test memory fault done");
      summarize();
   end
endmodule : ecr_regs_bench
